// *** ssl_pkg.sv ***
// shared constants and types for the software stroke limit checker
`default_nettype none
package ssl_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_UPPER = 8'h00;
  localparam logic [7:0] ADDR_LOWER = 8'h04;
  localparam logic [7:0] ADDR_CFG   = 8'h08;
  localparam logic [7:0] ADDR_STAT  = 8'h0c;

  // ------------------------------------------------------------
  // reset values and field positions
  // ------------------------------------------------------------
  localparam logic [31:0] UPPER_RST   = 32'h7fffffff;
  localparam logic [31:0] LOWER_RST   = 32'h80000000;
  localparam logic        SEL_RST     = 1'h0;  // current feed position
  localparam logic        MAN_EN_RST  = 1'h0;  // manual check invalid
  localparam logic        DEG_RST     = 1'h0;
  localparam int          CFG_SEL_BIT = 0;
  localparam int          CFG_MAN_BIT = 1;
  localparam int          CFG_DEG_BIT = 2;
  localparam int          STAT_CLR_BIT = 0;
  localparam int          STAT_ERR_BIT = 16;
  localparam int          STAT_RUN_BIT = 17;
  localparam int          CODE_W      = 10;

  // ------------------------------------------------------------
  // error codes
  // ------------------------------------------------------------
  localparam logic [9:0] ERR_START_PLUS  = 10'h1fb;  // 507
  localparam logic [9:0] ERR_START_MINUS = 10'h1fc;  // 508
  localparam logic [9:0] ERR_CMD_PLUS    = 10'h1fd;
  localparam logic [9:0] ERR_CMD_MINUS   = 10'h1fe;
  localparam logic [9:0] ERR_NONE        = 10'h000;

  // ------------------------------------------------------------
  // control type codes
  // ------------------------------------------------------------
  localparam logic [3:0] CTL_ZRET_MACH = 4'h0;
  localparam logic [3:0] CTL_ZRET_FAST = 4'h1;
  localparam logic [3:0] CTL_LIN1      = 4'h2;
  localparam logic [3:0] CTL_LIN2      = 4'h3;
  localparam logic [3:0] CTL_FIX1      = 4'h4;
  localparam logic [3:0] CTL_FIX2      = 4'h5;
  localparam logic [3:0] CTL_CIRC      = 4'h6;
  localparam logic [3:0] CTL_SPEED     = 4'h7;
  localparam logic [3:0] CTL_SPD_POS   = 4'h8;
  localparam logic [3:0] CTL_CUR_CHG   = 4'h9;
  localparam logic [3:0] CTL_JUMP      = 4'ha;
  localparam logic [3:0] CTL_JOG       = 4'hb;
  localparam logic [3:0] CTL_MPG       = 4'hc;

  // motion states
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h1,
    ST_POS  = 4'h2,
    ST_SPD  = 4'h4,
    ST_MAN  = 4'h8
  } ssl_state_e;
endpackage
`default_nettype wire

// *** ssl_range_cmp.sv ***
// signed comparison of one address against the movable range
`default_nettype none
module ssl_range_cmp #(
  parameter int W = 32
) (
  // address and limits
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] upper,
  input  wire logic [W-1:0] lower,
  // result
  output logic              above,
  output logic              below
);
  // beyond the upper or under the lower limit
  assign above = $signed(value) > $signed(upper);
  assign below = $signed(value) < $signed(lower);
endmodule
`default_nettype wire

// *** ssl_stroke_check.sv ***
// per-axis software stroke limit checker with apb registers
`default_nettype none
module ssl_stroke_check (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // axis positions
  input  wire logic [31:0] current_feed_position,
  input  wire logic [31:0] machine_feed_position,
  input  wire logic [31:0] partner_position,
  // start request
  input  wire logic        start_req,
  input  wire logic [3:0]  start_ctl,
  input  wire logic        start_dir_plus,
  input  wire logic        start_pair,
  input  wire logic [31:0] target_address_or_move_amount,
  // run progress
  input  wire logic        next_entry_req,
  input  wire logic [31:0] next_target,
  input  wire logic        seg_done,
  input  wire logic        motion_done,
  // results
  output logic             start_ok,
  output logic             start_refuse,
  output logic             stop_immediate,
  output logic             stop_decel,
  output logic             axis_error,
  output logic [9:0]       error_code,
  output logic             running
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0]         stroke_upper_limit_r;
  logic [31:0]         stroke_lower_limit_r;
  logic                stroke_check_address_select_r;
  logic                manual_stroke_check_enable_r;
  logic                degree_unit_r;
  ssl_pkg::ssl_state_e state_r;
  ssl_pkg::ssl_state_e state_nxt;
  logic                running_r;
  logic                pair_r;
  logic                run_chk_r;
  logic                dir_plus_r;
  logic                pend_stop_r;
  logic [9:0]          pend_code_r;
  logic [31:0]         prdata_r;
  logic                pready_r;
  logic                pslverr_r;
  logic                start_ok_r;
  logic                start_refuse_r;
  logic                stop_imm_r;
  logic                stop_decel_r;
  logic                err_r;
  logic [9:0]          code_r;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire setup    = psel & ~penable & ~pready_r;
  wire wr_acc   = psel & penable & pwrite & pready_r;
  wire hit_up   = paddr == ssl_pkg::ADDR_UPPER;
  wire hit_lo   = paddr == ssl_pkg::ADDR_LOWER;
  wire hit_cfg  = paddr == ssl_pkg::ADDR_CFG;
  wire hit_st   = paddr == ssl_pkg::ADDR_STAT;
  wire mapped   = hit_up | hit_lo | hit_cfg | hit_st;
  wire err_clr  = wr_acc & hit_st & pwdata[ssl_pkg::STAT_CLR_BIT];
  wire [31:0] cfg_word = {29'h0000000, degree_unit_r, manual_stroke_check_enable_r,
                          stroke_check_address_select_r};
  wire [31:0] st_word  = {14'h0000, ~state_r[0], err_r, 6'h00, code_r};
  wire [31:0] rd_word  = hit_up  ? stroke_upper_limit_r :
                         hit_lo  ? stroke_lower_limit_r :
                         hit_cfg ? cfg_word :
                         hit_st  ? st_word : 32'h00000000;

  // ------------------------------------------------------------
  // control type decode
  // ------------------------------------------------------------
  wire is_zret   = start_ctl == ssl_pkg::CTL_ZRET_MACH | start_ctl == ssl_pkg::CTL_ZRET_FAST;
  wire is_jump   = start_ctl == ssl_pkg::CTL_JUMP;
  wire is_chg    = start_ctl == ssl_pkg::CTL_CUR_CHG;
  wire is_circ   = start_ctl == ssl_pkg::CTL_CIRC;
  wire is_interp = start_ctl == ssl_pkg::CTL_LIN2 | start_ctl == ssl_pkg::CTL_FIX2 | is_circ;
  wire is_pos    = is_interp | start_ctl == ssl_pkg::CTL_LIN1 | start_ctl == ssl_pkg::CTL_FIX1;
  wire is_speed  = start_ctl == ssl_pkg::CTL_SPEED | start_ctl == ssl_pkg::CTL_SPD_POS;
  wire is_manual = start_ctl == ssl_pkg::CTL_JOG | start_ctl == ssl_pkg::CTL_MPG;
  wire known     = is_zret | is_jump | is_chg | is_pos | is_speed | is_manual;
  // manual check only when enabled and not in degrees
  wire man_chk   = manual_stroke_check_enable_r & ~degree_unit_r;
  // start types that skip the check altogether
  wire no_check  = is_zret | is_jump | is_chg |
                   (is_speed & degree_unit_r) |
                   (is_manual & ~man_chk);

  // ------------------------------------------------------------
  // range comparisons
  // ------------------------------------------------------------
  wire [31:0] sel_pos = stroke_check_address_select_r ? machine_feed_position
                                                      : current_feed_position;
  wire [31:0] cmd_pos = state_r == ssl_pkg::ST_IDLE ? target_address_or_move_amount
                                                    : next_target;
  logic cur_above;
  logic cur_below;
  logic par_above;
  logic par_below;
  logic cmd_above;
  logic cmd_below;

  // own axis, partner axis, command endpoint
  ssl_range_cmp #(.W(32)) u_cur (
    .value (sel_pos),
    .upper (stroke_upper_limit_r),
    .lower (stroke_lower_limit_r),
    .above (cur_above),
    .below (cur_below)
  );
  ssl_range_cmp #(.W(32)) u_par (
    .value (partner_position),
    .upper (stroke_upper_limit_r),
    .lower (stroke_lower_limit_r),
    .above (par_above),
    .below (par_below)
  );
  ssl_range_cmp #(.W(32)) u_cmd (
    .value (cmd_pos),
    .upper (stroke_upper_limit_r),
    .lower (stroke_lower_limit_r),
    .above (cmd_above),
    .below (cmd_below)
  );

  // ------------------------------------------------------------
  // start evaluation
  // ------------------------------------------------------------
  wire chk_par   = is_interp | start_pair;
  wire cur_plus  = cur_above | (chk_par & par_above);
  wire cur_minus = cur_below | (chk_par & par_below);
  wire cmd_out   = is_pos & (cmd_above | cmd_below);
  wire away      = (cur_above & start_dir_plus) | (cur_below & ~start_dir_plus);
  wire man_fail  = (cur_above | cur_below) & (err_r | away);
  wire chk_fail  = is_manual ? man_fail : (cur_plus | cur_minus | cmd_out);
  wire fail      = known & ~no_check & chk_fail;
  wire start_now = ce & start_req & state_r == ssl_pkg::ST_IDLE;
  wire [9:0] start_code = (is_manual ? cur_above : cur_plus) ? ssl_pkg::ERR_START_PLUS :
                          (is_manual ? cur_below : cur_minus) ? ssl_pkg::ERR_START_MINUS :
                          cmd_above ? ssl_pkg::ERR_CMD_PLUS : ssl_pkg::ERR_CMD_MINUS;

  // ------------------------------------------------------------
  // run checks
  // ------------------------------------------------------------
  wire run_plus  = cur_above | (pair_r & par_above);
  wire run_minus = cur_below | (pair_r & par_below);
  wire pos_trip  = state_r == ssl_pkg::ST_POS & run_chk_r & (run_plus | run_minus);
  wire pend_trip = state_r == ssl_pkg::ST_POS & pend_stop_r & seg_done;
  wire man_trip  = state_r == ssl_pkg::ST_MAN & run_chk_r &
                   ((cur_above & dir_plus_r) | (cur_below & ~dir_plus_r));
  wire next_bad  = state_r == ssl_pkg::ST_POS & next_entry_req & (cmd_above | cmd_below);
  wire run_trip  = pos_trip | pend_trip | man_trip;
  wire [9:0] run_code = pos_trip ? (run_plus ? ssl_pkg::ERR_START_PLUS
                                             : ssl_pkg::ERR_START_MINUS) :
                        pend_trip ? pend_code_r :
                        (cur_above ? ssl_pkg::ERR_START_PLUS : ssl_pkg::ERR_START_MINUS);
  wire set_err   = (start_now & fail) | (ce & run_trip);

  // next motion state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ssl_pkg::ST_IDLE:
      begin
        if (start_req & ~fail & known & ~is_chg)
          state_nxt = is_pos ? ssl_pkg::ST_POS :
                      is_manual ? ssl_pkg::ST_MAN : ssl_pkg::ST_SPD;
      end
      ssl_pkg::ST_POS,
      ssl_pkg::ST_MAN:
      begin
        if (run_trip | motion_done)
          state_nxt = ssl_pkg::ST_IDLE;
      end
      ssl_pkg::ST_SPD:
      begin
        if (motion_done)
          state_nxt = ssl_pkg::ST_IDLE;
      end
      default:
        state_nxt = ssl_pkg::ST_IDLE;
    endcase
  end

  // apb registers and answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stroke_upper_limit_r          <= ssl_pkg::UPPER_RST;
      stroke_lower_limit_r          <= ssl_pkg::LOWER_RST;
      stroke_check_address_select_r <= ssl_pkg::SEL_RST;
      manual_stroke_check_enable_r  <= ssl_pkg::MAN_EN_RST;
      degree_unit_r                 <= ssl_pkg::DEG_RST;
      prdata_r                      <= 32'h00000000;
      pready_r                      <= 1'b0;
      pslverr_r                     <= 1'b0;
    end
    else if (ce)
    begin
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
      prdata_r  <= (setup & ~pwrite) ? rd_word : 32'h00000000;
      if (wr_acc & hit_up)
        stroke_upper_limit_r <= pwdata;
      if (wr_acc & hit_lo)
        stroke_lower_limit_r <= pwdata;
      if (wr_acc & hit_cfg)
      begin
        stroke_check_address_select_r <= pwdata[ssl_pkg::CFG_SEL_BIT];
        manual_stroke_check_enable_r  <= pwdata[ssl_pkg::CFG_MAN_BIT];
        degree_unit_r                 <= pwdata[ssl_pkg::CFG_DEG_BIT];
      end
    end
  end

  // motion state and run context
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r     <= ssl_pkg::ST_IDLE;
      running_r   <= 1'b0;
      pair_r      <= 1'b0;
      run_chk_r   <= 1'b0;
      dir_plus_r  <= 1'b0;
      pend_stop_r <= 1'b0;
      pend_code_r <= ssl_pkg::ERR_NONE;
    end
    else if (ce)
    begin
      state_r   <= state_nxt;
      running_r <= state_nxt != ssl_pkg::ST_IDLE; // flop copy keeps the output registered
      if (start_now)
      begin
        pair_r      <= chk_par;
        run_chk_r   <= is_manual ? man_chk : (is_pos & ~is_circ);
        dir_plus_r  <= start_dir_plus;
        pend_stop_r <= 1'b0;
      end
      else if (next_bad & ~pend_stop_r)
      begin
        pend_stop_r <= 1'b1;
        pend_code_r <= cmd_above ? ssl_pkg::ERR_CMD_PLUS : ssl_pkg::ERR_CMD_MINUS;
      end
    end
  end

  // result pulses and error latch; a new error wins over a reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_ok_r     <= 1'b0;
      start_refuse_r <= 1'b0;
      stop_imm_r     <= 1'b0;
      stop_decel_r   <= 1'b0;
      err_r          <= 1'b0;
      code_r         <= ssl_pkg::ERR_NONE;
    end
    else if (ce)
    begin
      start_ok_r     <= start_now & ~fail;
      start_refuse_r <= ce & start_req & (fail | state_r != ssl_pkg::ST_IDLE);
      stop_imm_r     <= pos_trip | pend_trip;
      stop_decel_r   <= man_trip;
      if (set_err)
      begin
        err_r  <= 1'b1;
        code_r <= start_now ? start_code : run_code;
      end
      else if (err_clr)
        err_r <= 1'b0;
    end
  end

  // outputs
  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign start_ok       = start_ok_r;
  assign start_refuse   = start_refuse_r;
  assign stop_immediate = stop_imm_r;
  assign stop_decel     = stop_decel_r;
  assign axis_error     = err_r;
  assign error_code     = code_r;
  assign running        = running_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_idle_start;
    ce & start_req & state_r == ssl_pkg::ST_IDLE;
  endsequence
  sequence s_refused;
    ##1 (start_refuse & ~start_ok & state_r == ssl_pkg::ST_IDLE);
  endsequence

  property p_skip_zret;
    @(posedge pclk) disable iff (!presetn)
    s_idle_start and (is_zret | is_jump) |=> start_ok & ~start_refuse;
  endproperty
  a_skip_zret: assert property (p_skip_zret) else $error("zero return was checked");

  property p_cmd_fail;
    @(posedge pclk) disable iff (!presetn)
    s_idle_start and is_pos & (cmd_above | cmd_below) |-> s_refused;
  endproperty
  a_cmd_fail: assert property (p_cmd_fail) else $error("bad endpoint started");

  property p_start_plus;
    @(posedge pclk) disable iff (!presetn)
    s_idle_start and is_pos & cur_above |=> axis_error & error_code == 10'h1fb;
  endproperty
  a_start_plus: assert property (p_start_plus) else $error("code 507 missing");

  property p_chg_no_err;
    @(posedge pclk) disable iff (!presetn)
    s_idle_start and is_chg and ~axis_error |=> ~axis_error & start_ok;
  endproperty
  a_chg_no_err: assert property (p_chg_no_err) else $error("value change flagged");

  property p_pos_stop;
    @(posedge pclk) disable iff (!presetn)
    ce & pos_trip |=> stop_immediate & ~stop_decel ##1 ~stop_immediate;
  endproperty
  a_pos_stop: assert property (p_pos_stop) else $error("no immediate stop");

  property p_man_stop;
    @(posedge pclk) disable iff (!presetn)
    ce & man_trip |=> stop_decel & ~stop_immediate & ~running;
  endproperty
  a_man_stop: assert property (p_man_stop) else $error("no deceleration stop");

  property p_speed_run;
    @(posedge pclk) disable iff (!presetn)
    state_r == ssl_pkg::ST_SPD |-> ~stop_imm_r ##1 ~stop_immediate;
  endproperty
  a_speed_run: assert property (p_speed_run) else $error("speed run stopped");

  property p_man_reset;
    @(posedge pclk) disable iff (!presetn)
    s_idle_start and is_manual & man_chk & axis_error & (cur_above | cur_below) |-> s_refused;
  endproperty
  a_man_reset: assert property (p_man_reset) else $error("manual start before reset");

  property p_pair;
    @(posedge pclk) disable iff (!presetn)
    s_idle_start and is_pos & chk_par & (par_above | par_below) |-> s_refused;
  endproperty
  a_pair: assert property (p_pair) else $error("pair started with bad axis");

  property p_pend;
    @(posedge pclk) disable iff (!presetn)
    ce & pend_stop_r & state_r == ssl_pkg::ST_POS & ~seg_done & ~run_trip & ~motion_done
      |=> ~stop_immediate;
  endproperty
  a_pend: assert property (p_pend) else $error("stopped before entry done");
endmodule
`default_nettype wire

// *** ssl_axis_model.sv ***
// servo side model: feedback positions seen by the stroke checker
`default_nettype none
module ssl_axis_model #(
  parameter logic [31:0] MACH_OFS = 32'h00000020
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // commanded position
  input  wire logic [31:0] pos_set,
  // feedback
  output logic [31:0]      cur_pos,
  output logic [31:0]      mach_pos
);
  timeunit 1ns;
  timeprecision 1ns;
  // feedback lags command one cycle, machine value offset from it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cur_pos  <= 32'h00000000;
      mach_pos <= MACH_OFS;
    end
    else
    begin
      cur_pos  <= pos_set;
      mach_pos <= pos_set + MACH_OFS;
    end
endmodule
`default_nettype wire

// *** ssl_stroke_check_tb.sv ***
// self-checking bench for the stroke limit checker
`default_nettype none
module ssl_stroke_check_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, pp = 32'h0, pos = 32'h0, tgt = 32'h0, ntgt = 32'h0;
  logic [31:0] prdata, cur, mach, rdv;
  logic        sreq = 1'b0, dirp = 1'b0, pair = 1'b0, nreq = 1'b0, segd = 1'b0, mdone = 1'b0;
  logic        ce = 1'b1;
  logic        pready, pslverr, ok, rf, simm, sdec, aerr, run, e;
  logic [3:0]  ctl = 4'h0;
  logic [9:0]  code;
  int          num_errors = 0, check_count = 0, cyc = 0;

  ssl_axis_model axis (.pclk(pclk), .presetn(presetn), .pos_set(pos), .cur_pos(cur),
    .mach_pos(mach));
  ssl_stroke_check dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .current_feed_position(cur),
    .machine_feed_position(mach), .partner_position(pp), .start_req(sreq),
    .start_ctl(ctl), .start_dir_plus(dirp), .start_pair(pair),
    .target_address_or_move_amount(tgt), .next_entry_req(nreq), .next_target(ntgt),
    .seg_done(segd), .motion_done(mdone), .start_ok(ok), .start_refuse(rf),
    .stop_immediate(simm), .stop_decel(sdec), .axis_error(aerr), .error_code(code),
    .running(run));

  // clock and hang guard
  always #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    check_count++;
    if (g !== x)
    begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    // answer taken at the edge that sees pready, request released only now
    rdv = prdata;
    e   = pslverr;
    chk({31'h0, pready}, 32'h1, "pready");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input string m);
    apb(1'b0, a, 32'h0);
    chk(rdv, x, m);
  endtask

  task automatic clr;
    apb(1'b1, ssl_pkg::ADDR_STAT, 32'h1);
  endtask

  task automatic setp(input logic [31:0] v);
    @(posedge pclk);
    pos <= v;
    repeat (2) @(posedge pclk);
  endtask

  // start request; xc of zero skips the code compare
  task automatic go(input logic [3:0] c, input logic d, input logic p,
    input logic [31:0] t, input logic xok, input logic [9:0] xc);
    @(posedge pclk);
    sreq <= 1'b1;
    ctl  <= c;
    dirp <= d;
    pair <= p;
    tgt  <= t;
    @(posedge pclk);
    sreq <= 1'b0;
    #1;
    chk({31'h0, ok}, {31'h0, xok}, "start ok");
    chk({31'h0, rf}, {31'h0, ~xok}, "refuse");
    chk({31'h0, run}, {31'h0, xok && c != ssl_pkg::CTL_CUR_CHG}, "running");
    if (xc !== 10'h0)
      chk({22'h0, code}, {22'h0, xc}, "code");
  endtask

  // move while running, look for stop pulses, then end the motion
  task automatic watch(input logic [31:0] v, input logic xi, input logic xd);
    logic si, sd;
    si = 1'b0;
    sd = 1'b0;
    @(posedge pclk);
    pos <= v;
    repeat (5)
    begin
      @(negedge pclk);
      si |= simm;
      sd |= sdec;
    end
    chk({31'h0, si}, {31'h0, xi}, "stop imm");
    chk({31'h0, sd}, {31'h0, xd}, "stop decel");
    @(posedge pclk);
    mdone <= 1'b1;
    @(posedge pclk);
    mdone <= 1'b0;
  endtask

  // main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ssl_pkg::ADDR_UPPER, ssl_pkg::UPPER_RST, "upper rst");
    rdchk(ssl_pkg::ADDR_LOWER, ssl_pkg::LOWER_RST, "lower rst");
    rdchk(ssl_pkg::ADDR_CFG, 32'h0, "cfg rst");
    apb(1'b1, 8'h10, 32'h5);
    chk({31'h0, e}, 32'h1, "unmapped");
    apb(1'b1, ssl_pkg::ADDR_UPPER, 32'h64);
    apb(1'b1, ssl_pkg::ADDR_LOWER, 32'hffffff9c);
    rdchk(ssl_pkg::ADDR_LOWER, 32'hffffff9c, "lower wr");
    $display("test registers done");
    setp(32'h96);
    go(ssl_pkg::CTL_ZRET_MACH, 1'b0, 1'b0, 32'h0, 1'b1, 10'h0);
    watch(32'h96, 1'b0, 1'b0);
    go(ssl_pkg::CTL_JUMP, 1'b0, 1'b0, 32'h0, 1'b1, 10'h0);
    watch(32'h96, 1'b0, 1'b0);
    go(ssl_pkg::CTL_LIN1, 1'b0, 1'b0, 32'h0, 1'b0, ssl_pkg::ERR_START_PLUS);
    rdchk(ssl_pkg::ADDR_STAT, 32'h000101fb, "status");
    clr();
    setp(32'hffffff6a);
    go(ssl_pkg::CTL_LIN1, 1'b0, 1'b0, 32'h0, 1'b0, ssl_pkg::ERR_START_MINUS);
    clr();
    setp(32'h0);
    go(ssl_pkg::CTL_CUR_CHG, 1'b0, 1'b0, 32'h96, 1'b1, 10'h0);
    for (int c = 2; c < 7; c++)
    begin
      go(c[3:0], 1'b0, 1'b0, 32'h96, 1'b0, ssl_pkg::ERR_CMD_PLUS);
      clr();
    end
    go(ssl_pkg::CTL_LIN1, 1'b0, 1'b0, 32'hffffff6a, 1'b0, ssl_pkg::ERR_CMD_MINUS);
    clr();
    pp <= 32'h96;
    go(ssl_pkg::CTL_LIN2, 1'b0, 1'b1, 32'h0, 1'b0, 10'h0);
    clr();
    pp <= 32'h0;
    $display("test start checks done");
    go(ssl_pkg::CTL_LIN1, 1'b0, 1'b0, 32'h50, 1'b1, 10'h0);
    watch(32'h96, 1'b1, 1'b0);
    chk({31'h0, aerr}, 32'h1, "run error");
    clr();
    setp(32'h0);
    go(ssl_pkg::CTL_CIRC, 1'b0, 1'b0, 32'h10, 1'b1, 10'h0);
    watch(32'h96, 1'b0, 1'b0);
    setp(32'h0);
    go(ssl_pkg::CTL_SPEED, 1'b0, 1'b0, 32'h0, 1'b1, 10'h0);
    watch(32'h96, 1'b0, 1'b0);
    setp(32'h0);
    go(ssl_pkg::CTL_LIN1, 1'b0, 1'b0, 32'h10, 1'b1, 10'h0);
    @(posedge pclk);
    nreq <= 1'b1;
    ntgt <= 32'h96;
    @(posedge pclk);
    nreq <= 1'b0;
    segd <= 1'b1;
    @(posedge pclk);
    segd <= 1'b0;
    #1;
    chk({31'h0, simm}, 32'h1, "path stop");
    chk({22'h0, code}, {22'h0, ssl_pkg::ERR_CMD_PLUS}, "path code");
    watch(32'h0, 1'b0, 1'b0);
    clr();
    $display("test run checks done");
    go(ssl_pkg::CTL_JOG, 1'b1, 1'b0, 32'h0, 1'b1, 10'h0);
    watch(32'hc8, 1'b0, 1'b0);
    setp(32'h0);
    apb(1'b1, ssl_pkg::ADDR_CFG, 32'h2);
    go(ssl_pkg::CTL_JOG, 1'b1, 1'b0, 32'h96, 1'b1, 10'h0);
    watch(32'h96, 1'b0, 1'b1);
    go(ssl_pkg::CTL_MPG, 1'b1, 1'b0, 32'h0, 1'b0, 10'h0);
    clr();
    go(ssl_pkg::CTL_MPG, 1'b1, 1'b0, 32'h0, 1'b0, 10'h0);
    clr();
    go(ssl_pkg::CTL_MPG, 1'b0, 1'b0, 32'h0, 1'b1, 10'h0);
    watch(32'h50, 1'b0, 1'b0);
    apb(1'b1, ssl_pkg::ADDR_CFG, 32'h6);
    setp(32'h96);
    go(ssl_pkg::CTL_SPEED, 1'b1, 1'b0, 32'h0, 1'b1, 10'h0);
    watch(32'hc8, 1'b0, 1'b0);
    go(ssl_pkg::CTL_JOG, 1'b1, 1'b0, 32'h0, 1'b1, 10'h0);
    watch(32'hc8, 1'b0, 1'b0);
    apb(1'b1, ssl_pkg::ADDR_CFG, 32'h1);
    setp(32'h50);
    go(ssl_pkg::CTL_LIN1, 1'b0, 1'b0, 32'h0, 1'b0, ssl_pkg::ERR_START_PLUS);
    clr();
    apb(1'b1, ssl_pkg::ADDR_CFG, 32'h0);
    go(ssl_pkg::CTL_LIN1, 1'b0, 1'b0, 32'h0, 1'b1, 10'h0);
    watch(32'h0, 1'b0, 1'b0);
    // a frozen block takes no start
    @(posedge pclk);
    ce   <= 1'b0;
    sreq <= 1'b1;
    ctl  <= ssl_pkg::CTL_LIN1;
    tgt  <= 32'h0;
    repeat (2) @(posedge pclk);
    sreq <= 1'b0;
    chk({30'h0, ok, run}, 32'h0, "ce freeze");
    ce   <= 1'b1;
    $display("test manual and select done");
    wrap_up();
  end
endmodule
`default_nettype wire
